// *** rtl/pss_dwell_timer.sv ***
// dwell timer: counts 2^n ticks after a start pulse
// assumes a one-cycle tick enable from the sequencer clock divider
`timescale 1ns/100ps
`default_nettype none
module pss_dwell_timer
   import pss_pkg::*;
#(
   parameter int EXP_W = PSS_DWELL_W
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic start,
   input wire logic tick,
   input wire logic [EXP_W-1:0] exponent,
   output logic done
);

   // ****************************************************************
   // counter
   // ****************************************************************
   logic [32:0] count;
   logic [32:0] next_count;
   logic [32:0] target;
   logic running;
   logic next_running;

   always_comb begin
      target = 33'h0_0000_0001 << exponent;
      next_count = count;
      next_running = running;
      if (start) begin
         next_count = 33'h0_0000_0000;
         next_running = 1'b1;
      end else if (running && tick && count < target) begin
         next_count = count + 33'h0_0000_0001;
      end
   end

   // no path back from start, so no loop through the state machine
   // held once reached, so a lowered live exponent cannot hang it
   assign done = running && count >= target;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         count <= 33'h0_0000_0000;
         running <= 1'b0;
      end else begin
         count <= next_count;
         running <= next_running;
      end
   end

endmodule : pss_dwell_timer
`default_nettype wire

// *** rtl/pss_sequencer.sv ***
// power state supply sequencer with supply registers for wake2, awake, sleep1 and sleep2
// assumes synchronous inputs and a one-cycle register port
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module pss_sequencer
   import pss_pkg::*;
#(
   parameter int SLOW_DIV = PSS_SLOW_DIV
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   input wire logic wake_event,
   input wire pss_good_t supply_good,
   output pss_supply_t supply_ctrl,
   output pss_state_t seq_state
);

   // ****************************************************************
   // registers
   // ****************************************************************
   logic [31:0] w2_cfg;
   logic [31:0] awake_cfg;
   logic [31:0] s1_cfg;
   logic [31:0] s2_cfg;
   logic fast_clk_sel;
   logic sleep_req;
   logic [31:0] next_w2_cfg;
   logic [31:0] next_awake_cfg;
   logic [31:0] next_s1_cfg;
   logic [31:0] next_s2_cfg;
   logic next_fast_clk_sel;
   logic next_sleep_req;
   logic [31:0] next_rdata;

   always_comb begin
      next_w2_cfg = w2_cfg;
      next_awake_cfg = awake_cfg;
      next_s1_cfg = s1_cfg;
      next_s2_cfg = s2_cfg;
      next_fast_clk_sel = fast_clk_sel;
      next_sleep_req = sleep_req;
      // device clears the request once it leaves awake
      if (sleep_req && seq_state != PSS_AWAKE) begin
         next_sleep_req = 1'b0;
      end
      if (reg_write) begin
         case (reg_addr)
            PSS_ADDR_CTRL: begin
               next_fast_clk_sel = reg_wdata[PSS_CTRL_WAKE_BIT];
               if (reg_wdata[PSS_CTRL_SLEEP_BIT] &&
                   seq_state == PSS_AWAKE) begin
                  next_sleep_req = 1'b1;
               end
            end
            PSS_ADDR_W2: begin
               next_w2_cfg = (reg_wdata & PSS_DWELL_MASK) |
                  PSS_FIXED_ONE;
            end
            PSS_ADDR_AWAKE: begin
               next_awake_cfg = (reg_wdata & PSS_AWAKE_MASK) |
                  PSS_FIXED_ONE;
            end
            PSS_ADDR_S1: begin
               next_s1_cfg = (reg_wdata & PSS_DWELL_MASK) |
                  PSS_FIXED_ONE;
            end
            PSS_ADDR_S2: begin
               next_s2_cfg = (reg_wdata & PSS_DWELL_MASK) |
                  PSS_FIXED_ONE;
            end
            default: begin
               next_fast_clk_sel = fast_clk_sel;
            end
         endcase
      end
   end

   // ****************************************************************
   // read port
   // ****************************************************************
   logic [31:0] cur_cfg;

   always_comb begin
      next_rdata = 32'h0000_0000;
      if (reg_read) begin
         case (reg_addr)
            PSS_ADDR_CTRL: begin
               next_rdata[PSS_CTRL_WAKE_BIT] = fast_clk_sel;
               next_rdata[PSS_CTRL_SLEEP_BIT] = sleep_req;
            end
            PSS_ADDR_W2: next_rdata = w2_cfg;
            PSS_ADDR_AWAKE: next_rdata = awake_cfg;
            PSS_ADDR_S1: next_rdata = s1_cfg;
            PSS_ADDR_S2: next_rdata = s2_cfg;
            PSS_ADDR_STATUS: begin
               next_rdata = cur_cfg & PSS_AWAKE_MASK;
               next_rdata[PSS_ANA_EN_BIT] = cur_cfg[PSS_ANA_EN_BIT];
               next_rdata[PSS_STAT_STATE_LSB +: 3] = seq_state;
            end
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         w2_cfg <= PSS_W2_RESET;
         awake_cfg <= PSS_AWAKE_RESET;
         s1_cfg <= PSS_S1_RESET;
         s2_cfg <= PSS_S2_RESET;
         fast_clk_sel <= 1'b0;
         sleep_req <= 1'b0;
         reg_rdata <= 32'h0000_0000;
      end else begin
         w2_cfg <= next_w2_cfg;
         awake_cfg <= next_awake_cfg;
         s1_cfg <= next_s1_cfg;
         s2_cfg <= next_s2_cfg;
         fast_clk_sel <= next_fast_clk_sel;
         sleep_req <= next_sleep_req;
         reg_rdata <= next_rdata;
      end
   end

   // ****************************************************************
   // sequencer clock tick
   // ****************************************************************
   logic [15:0] div_cnt;
   logic [15:0] next_div_cnt;
   logic tick;

   always_comb begin
      next_div_cnt = div_cnt + 16'h0001;
      if (div_cnt == 16'(SLOW_DIV - 1)) begin
         next_div_cnt = 16'h0000;
      end
   end

   // slow tick unless the fast clock is selected
   assign tick = fast_clk_sel || div_cnt == 16'(SLOW_DIV - 1);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         div_cnt <= 16'h0000;
      end else begin
         div_cnt <= next_div_cnt;
      end
   end

   // ****************************************************************
   // state machine
   // ****************************************************************
   pss_state_t next_state;
   logic dwell_done;
   logic enter;
   logic all_good;
   logic [PSS_DWELL_W-1:0] cur_exp;

   always_comb begin
      case (seq_state)
         PSS_WAKE2: cur_cfg = w2_cfg;
         PSS_AWAKE: cur_cfg = awake_cfg;
         PSS_SLEEP1: cur_cfg = s1_cfg;
         PSS_SLEEP2: cur_cfg = s2_cfg;
         PSS_WAKE1: cur_cfg = PSS_W1_CFG;
         default: cur_cfg = PSS_ASLEEP_CFG;
      endcase
   end

   assign cur_exp = cur_cfg[PSS_DWELL_LSB +: PSS_DWELL_W];

   // every supply enabled in the current state must be good
   assign all_good =
      (!cur_cfg[PSS_IO_EN_BIT] || supply_good.io_good) &&
      (!cur_cfg[PSS_PLL_EN_BIT] || supply_good.pll_good) &&
      (!cur_cfg[PSS_ANA_EN_BIT] || supply_good.analogue_good) &&
      (!cur_cfg[PSS_CORE_EN_BIT] || supply_good.core_good);

   always_comb begin
      next_state = seq_state;
      case (seq_state)
         PSS_ASLEEP: begin
            if (wake_event) next_state = PSS_WAKE1;
         end
         PSS_WAKE1: begin
            if (all_good) next_state = PSS_WAKE2;
         end
         PSS_WAKE2: begin
            if (dwell_done && all_good) begin
               next_state = PSS_AWAKE;
            end
         end
         PSS_AWAKE: begin
            if (sleep_req) next_state = PSS_SLEEP1;
         end
         PSS_SLEEP1: begin
            if (dwell_done) next_state = PSS_SLEEP2;
         end
         PSS_SLEEP2: begin
            if (dwell_done) next_state = PSS_ASLEEP;
         end
         default: next_state = PSS_ASLEEP;
      endcase
   end

   assign enter = next_state != seq_state;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         seq_state <= PSS_AWAKE;
      end else begin
         seq_state <= next_state;
      end
   end

   pss_dwell_timer #(
      .EXP_W(PSS_DWELL_W)
   ) u_dwell (
      .clk(clk),
      .rst_b(rst_b),
      .start(enter || (seq_state == PSS_AWAKE)),
      .tick(tick),
      .exponent(cur_exp),
      .done(dwell_done)
   );

   // ****************************************************************
   // supply outputs
   // ****************************************************************
   pss_supply_t next_supply;

   always_comb begin
      next_supply.tile_clk_off = cur_cfg[PSS_TILE_OFF_BIT];
      next_supply.ana_pfm = cur_cfg[PSS_ANA_PFM_BIT];
      next_supply.core_pfm = cur_cfg[PSS_CORE_PFM_BIT];
      next_supply.io_supply_output_en = cur_cfg[PSS_IO_EN_BIT];
      next_supply.pll_supply_regulator_en =
         cur_cfg[PSS_PLL_EN_BIT];
      next_supply.analogue_rail_converter_en =
         cur_cfg[PSS_ANA_EN_BIT];
      next_supply.core_rail_converter_en =
         cur_cfg[PSS_CORE_EN_BIT];
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         supply_ctrl <= pss_supply_t'(7'h0F);
      end else begin
         supply_ctrl <= next_supply;
      end
   end

endmodule : pss_sequencer
`default_nettype wire

// *** shared/pss_pkg.sv ***
// constants and types for the power state supply sequencer
// assumes one 200 MHz clock domain and a plain register port
package pss_pkg;

   // ****************************************************************
   // register map
   // ****************************************************************
   localparam logic [7:0] PSS_ADDR_CTRL = 8'h00;
   localparam logic [7:0] PSS_ADDR_W2 = 8'h14;
   localparam logic [7:0] PSS_ADDR_AWAKE = 8'h18;
   localparam logic [7:0] PSS_ADDR_S1 = 8'h1C;
   localparam logic [7:0] PSS_ADDR_S2 = 8'h20;
   localparam logic [7:0] PSS_ADDR_STATUS = 8'h24;

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int PSS_DWELL_LSB = 16;
   localparam int PSS_DWELL_W = 5;
   localparam int PSS_TILE_OFF_BIT = 14;
   localparam int PSS_ANA_PFM_BIT = 9;
   localparam int PSS_CORE_PFM_BIT = 8;
   localparam int PSS_IO_EN_BIT = 5;
   localparam int PSS_PLL_EN_BIT = 4;
   localparam int PSS_ANA_EN_BIT = 1;
   localparam int PSS_CORE_EN_BIT = 0;
   localparam int PSS_CTRL_SLEEP_BIT = 1;
   localparam int PSS_CTRL_WAKE_BIT = 0;
   localparam int PSS_STAT_STATE_LSB = 16;

   // writable bits of dwell and awake registers
   localparam logic [31:0] PSS_DWELL_MASK = 32'h001F_4331;
   localparam logic [31:0] PSS_AWAKE_MASK = 32'h0000_4331;
   localparam logic [31:0] PSS_FIXED_ONE = 32'h0000_0002;

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [31:0] PSS_W2_RESET = 32'h0010_0033;
   localparam logic [31:0] PSS_AWAKE_RESET = 32'h0000_0033;
   localparam logic [31:0] PSS_S1_RESET = 32'h0010_0022;
   localparam logic [31:0] PSS_S2_RESET = 32'h0010_0002;
   localparam logic [31:0] PSS_ASLEEP_CFG = 32'h0000_0002;
   localparam logic [31:0] PSS_W1_CFG = 32'h0000_0022;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int PSS_CLK_MHZ = 200;
   localparam int PSS_SLOW_TICK_NS = 32000;
   localparam int PSS_SLOW_DIV = (PSS_SLOW_TICK_NS * PSS_CLK_MHZ) / 1000;

   // ****************************************************************
   // types
   // ****************************************************************
   typedef enum logic [2:0] {
      PSS_ASLEEP = 3'h0,
      PSS_WAKE1 = 3'h1,
      PSS_WAKE2 = 3'h3,
      PSS_AWAKE = 3'h2,
      PSS_SLEEP1 = 3'h6,
      PSS_SLEEP2 = 3'h7
   } pss_state_t;

   typedef struct packed {
      logic tile_clk_off;
      logic ana_pfm;
      logic core_pfm;
      logic io_supply_output_en;
      logic pll_supply_regulator_en;
      logic analogue_rail_converter_en;
      logic core_rail_converter_en;
   } pss_supply_t;

   typedef struct packed {
      logic io_good;
      logic pll_good;
      logic analogue_good;
      logic core_good;
   } pss_good_t;

endpackage : pss_pkg

// *** tb/pss_sequencer_bench.sv ***
// bench: register access, then a full sleep and wake walk
// assumes the checker bind and the supply model beside the dut
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
   failures++; $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); \
   end end
module pss_sequencer_bench
   import pss_pkg::*;
;
   logic clk, rst_b, reg_write, reg_read, wake_event;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [3:0] hold_bad;
   pss_good_t supply_good;
   pss_supply_t supply_ctrl;
   pss_state_t seq_state;
   int failures, n_tests, n;
   logic [7:0] adr [4] = '{8'h14, 8'h18, 8'h1C, 8'h20};
   logic [31:0] rv [4] = '{32'h0010_0033, 32'h0000_0033, 32'h0010_0022,
      32'h0010_0002};
   pss_sequencer #(.SLOW_DIV(4)) dut (.clk(clk), .rst_b(rst_b),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .wake_event(wake_event),
      .supply_good(supply_good), .supply_ctrl(supply_ctrl),
      .seq_state(seq_state));
   pss_supply_model #(.RAMP(3)) u_model (.clk(clk), .rst_b(rst_b),
      .supply_ctrl(supply_ctrl), .hold_bad(hold_bad),
      .supply_good(supply_good));
   always #2.5 clk = ~clk;
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] x, string nm);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      #1;
      `CHK(nm, x, reg_rdata)
   endtask : rd
   task automatic step();
      @(posedge clk);
      #1;
   endtask : step
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : summarize
   task automatic wait_st(input pss_state_t s, output int k);
      k = 0;
      #1;
      while (seq_state !== s) begin
         step();
         k++;
         if (k > 3000) begin
            failures++;
            $display("CHECK FAILED state exp %0h got %0h", s, seq_state);
            summarize();
         end
      end
   endtask : wait_st
   initial begin
      clk = 1'b0;
      rst_b = 1'b0;
      {reg_write, reg_read, wake_event} = 3'h0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      hold_bad = 4'h0;
      failures = 0;
      n_tests = 0;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      #1;
      `CHK("state", PSS_AWAKE, seq_state)
      `CHK("outputs", 7'h0F, supply_ctrl)
      for (int i = 0; i < 4; i++) rd(adr[i], rv[i], "reset");
      rd(PSS_ADDR_STATUS, {13'h0000, PSS_AWAKE, 16'h0000} | PSS_AWAKE_RESET,
         "status");
      rd(PSS_ADDR_CTRL, 32'h0000_0000, "ctrl");
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         wr(adr[i], 32'hFFFF_FFFF);
         rd(adr[i], (i == 1) ? 32'h4333 : 32'h001F_4333, "ones");
         wr(adr[i], 32'h0);
         rd(adr[i], 32'h0000_0002, "zeros");
      end
      rd(8'h40, 32'h0, "unmapped");
      $display("test access done");
      wr(8'h1C, 32'h0003_4123);
      wr(8'h20, 32'h0002_0212);
      wr(8'h14, 32'h0002_0033);
      wr(8'h18, 32'h0000_0033);
      wr(8'h00, 32'h3);
      wait_st(PSS_SLEEP1, n);
      step();
      `CHK("sleep1", 7'h5B, supply_ctrl)
      wait_st(PSS_SLEEP2, n);
      `CHK("dwell1", 1'b1, n + 1 >= 8 && n + 1 <= 12)
      step();
      `CHK("sleep2", 7'h26, supply_ctrl)
      wait_st(PSS_ASLEEP, n);
      `CHK("dwell2", 1'b1, n + 1 >= 4 && n + 1 <= 8)
      repeat (6) step();
      `CHK("asleep", 7'h02, supply_ctrl)
      `CHK("hold", PSS_ASLEEP, seq_state)
      @(posedge clk);
      wake_event <= 1'b1;
      hold_bad <= 4'h4;
      wait_st(PSS_WAKE1, n);
      @(posedge clk);
      wake_event <= 1'b0;
      wait_st(PSS_WAKE2, n);
      wr(8'h00, 32'h3);
      rd(PSS_ADDR_CTRL, 32'h0000_0001, "ignored");
      repeat (20) step();
      `CHK("stall", PSS_WAKE2, seq_state)
      @(posedge clk);
      hold_bad <= 4'h0;
      wait_st(PSS_AWAKE, n);
      repeat (10) step();
      `CHK("awake", PSS_AWAKE, seq_state)
      `CHK("awake_out", 7'h0F, supply_ctrl)
      $display("test sleep walk done");
      wr(8'h00, 32'h2);
      wait_st(PSS_SLEEP1, n);
      wait_st(PSS_SLEEP2, n);
      `CHK("slow", 1'b1, n > 7 * 4 + 1 && n <= 8 * 4 + 2)
      $display("test slow tick done");
      summarize();
   end
endmodule : pss_sequencer_bench
`default_nettype wire

// *** tb/pss_sequencer_checker.sv ***
// port checker for the supply sequencer
// assumes it is bound into pss_sequencer
`timescale 1ns/100ps
`default_nettype none
module pss_sequencer_checker
   import pss_pkg::*;
#(
   parameter int SLOW_DIV = PSS_SLOW_DIV
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [31:0] reg_rdata,
   input wire logic wake_event,
   input wire pss_good_t supply_good,
   input wire pss_supply_t supply_ctrl,
   input wire pss_state_t seq_state
);
   // ****************************************************************
   // shadow registers and state history
   // ****************************************************************
   logic [3:0][31:0] sh;
   logic fast, wsel;
   pss_state_t last, nxt;
   logic [31:0] run, c, lim, rexp;
   logic [7:0] off;
   logic [4:0] e;
   pss_supply_t cexp;
   logic [3:0] good, en2;
   always_comb begin
      case (seq_state)
         PSS_ASLEEP: c = PSS_ASLEEP_CFG;
         PSS_WAKE1: c = PSS_W1_CFG;
         PSS_WAKE2: c = sh[0];
         PSS_AWAKE: c = sh[1];
         PSS_SLEEP1: c = sh[2];
         default: c = sh[3];
      endcase
      case (last)
         PSS_ASLEEP: nxt = PSS_WAKE1;
         PSS_WAKE1: nxt = PSS_WAKE2;
         PSS_WAKE2: nxt = PSS_AWAKE;
         PSS_AWAKE: nxt = PSS_SLEEP1;
         PSS_SLEEP1: nxt = PSS_SLEEP2;
         default: nxt = PSS_ASLEEP;
      endcase
   end
   assign e = c[20:16];
   assign cexp = {c[14], c[9], c[8], c[5], c[4], c[1], c[0]};
   assign lim = fast ? (32'h1 << e) + 32'h4
      : ((32'h1 << e) + 32'h2) * SLOW_DIV;
   assign off = reg_addr - PSS_ADDR_W2;
   assign wsel = (off[1:0] == 2'h0) && (off < 8'h10);
   assign rexp = wsel ? sh[off[3:2]] : 32'h0;
   assign good = supply_good;
   assign en2 = {sh[0][5], sh[0][4], sh[0][1], sh[0][0]};
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sh <= {PSS_S2_RESET, PSS_S1_RESET, PSS_AWAKE_RESET, PSS_W2_RESET};
         fast <= 1'b0;
         last <= PSS_AWAKE;
         run <= 32'h0;
      end else begin
         if (reg_write && wsel)
            sh[off[3:2]] <= (reg_wdata & ((off == 8'h4) ? PSS_AWAKE_MASK
               : PSS_DWELL_MASK)) | PSS_FIXED_ONE;
         if (reg_write && reg_addr == PSS_ADDR_CTRL)
            fast <= reg_wdata[0];
         last <= seq_state;
         run <= (seq_state == last) ? run + 32'h1 : 32'h1;
      end
   end
   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking dc @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence sleep_asked;
      reg_write && reg_addr == PSS_ADDR_CTRL && reg_wdata[1]
         && seq_state == PSS_AWAKE;
   endsequence
   sequence back_awake;
      last == PSS_WAKE2 && seq_state == PSS_AWAKE && !reg_write
         ##1 !reg_write;
   endsequence
   AST_READBACK: assert property (
      reg_read && reg_addr != PSS_ADDR_CTRL && reg_addr != PSS_ADDR_STATUS
      |=> reg_rdata == $past(rexp)) else $error("read data wrong");
   AST_SUPPLY_MAP: assert property (
      $stable(seq_state) && !$past(reg_write) && !$past(reg_write, 2)
      |-> supply_ctrl == $past(cexp)) else $error("supply outputs wrong");
   AST_ORDER: assert property (
      seq_state != last |-> seq_state == nxt)
      else $error("illegal state step");
   AST_DWELL_MIN: assert property (
      seq_state != last && last inside {PSS_WAKE2, PSS_SLEEP1, PSS_SLEEP2}
      |-> run >= (32'h1 << $past(e))) else $error("dwell cut short");
   AST_SLEEP_ADVANCE: assert property (
      seq_state == last && last inside {PSS_SLEEP1, PSS_SLEEP2}
      |-> run < lim) else $error("sleep phase overstays");
   AST_WAKE2_GOOD: assert property (
      last == PSS_WAKE2 && seq_state != last
      |-> (~$past(good) & $past(en2)) == 4'h0) else $error("left unsafe");
   AST_SLEEP_REQ: assert property (
      sleep_asked |-> ##[1:3] seq_state == PSS_SLEEP1)
      else $error("sleep request lost");
   AST_REQ_CLEARS: assert property (
      back_awake |-> seq_state == PSS_AWAKE [*2])
      else $error("stale sleep request");
endmodule : pss_sequencer_checker
bind pss_sequencer pss_sequencer_checker #(.SLOW_DIV(SLOW_DIV)) u_chk (
   .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
   .wake_event(wake_event), .supply_good(supply_good),
   .supply_ctrl(supply_ctrl), .seq_state(seq_state));
`default_nettype wire

// *** tb/pss_supply_model.sv ***
// supply regulator model: good follows enable after a ramp
// assumes supply_ctrl from the sequencer, hold_bad from the bench
`timescale 1ns/100ps
`default_nettype none
module pss_supply_model
   import pss_pkg::*;
#(
   parameter int RAMP = 3
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire pss_supply_t supply_ctrl,
   input wire logic [3:0] hold_bad,
   output pss_good_t supply_good
);
   logic [3:0] en;
   logic [RAMP-1:0][3:0] ramp;
   assign en = {supply_ctrl.io_supply_output_en,
      supply_ctrl.pll_supply_regulator_en,
      supply_ctrl.analogue_rail_converter_en,
      supply_ctrl.core_rail_converter_en};
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ramp <= '0;
         supply_good <= '0;
      end else begin
         ramp <= {ramp[RAMP-2:0], en};
         // good only after ramp, drops at once, held bad on demand
         supply_good <= en & ramp[RAMP-1] & ~hold_bad;
      end
   end
endmodule : pss_supply_model
`default_nettype wire
